/* File: verilog/rfsd_map.svh */
// Addresses, reset values and moduli of the RF divider control block.
// Assumes inclusion by bare name from the design files.
`ifndef RFSD_MAP_SVH
`define RFSD_MAP_SVH

// ****************************************
// Serial word layout
// ****************************************
`define RFSD_ADDR_MSB    2
`define RFSD_DATA_LSB    3
`define RFSD_WORD_MSB    23

// ****************************************
// Control word addresses
// ****************************************
`define RFSD_ADDR_REF    3'h0
`define RFSD_ADDR_FB     3'h1

// ****************************************
// Reset values of the data fields
// ****************************************
`define RFSD_REF_RESET   21'h000003
`define RFSD_FB_RESET    21'h100030

// ****************************************
// Dual-modulus prescaler base moduli
// ****************************************
`define RFSD_PRE_LO      5'h08
`define RFSD_PRE_HI      5'h10

`endif

/* File: verilog/rfsd_pkg.sv */
// Types of the RF divider control block: control word layouts and
// the power state. Assumes rfsd_map.svh for the numeric constants.
`default_nettype none

package rfsd_pkg;

  // ****************************************
  // Control word data fields, MSB first
  // ****************************************
  typedef struct packed {
    logic [1:0]  mux_select;
    logic        rf_counter_reset;
    logic        rf_pump_tristate;
    logic        rf_pump_gain;
    logic        rf_detector_polarity;
    logic [14:0] rf_reference_divide;
  } rfsd_ref_s;

  typedef struct packed {
    logic        rf_power_down;
    logic        rf_prescaler_select;
    logic [14:0] rf_binary_count;
    logic [3:0]  rf_swallow_count;
  } rfsd_fb_s;

  // ****************************************
  // Loop power state
  // ****************************************
  typedef enum logic [1:0] {
    PWR_ACTIVE     = 2'b00,
    PWR_WAIT_START = 2'b01,
    PWR_WAIT_END   = 2'b10,
    PWR_DOWN       = 2'b11
  } rfsd_power_e;

endpackage : rfsd_pkg

`default_nettype wire

/* File: verilog/rfsd_top.sv */
// RF synthesizer divider control: serial loader, control words,
// reference and feedback counters, phase detector and power modes.
// Assumes the host stops the serial clock while latch enable is high.
`default_nettype none
`timescale 1ns/1ns
`include "rfsd_map.svh"

// Contract
// - 15-bit reference divide field, ratio 3..32767
// - Polarity bit: 0 negative, 1 positive tuning
// - Gain bit: 0 low current, 1 high
// - Tri-state bit 1 puts pump high-impedance
// - Tri-state change acts without awaiting events
// - Tri-state with power-down picks power-down mode
// - Counter reset bit holds all three counters
// - Released counters restart aligned with reference
// - Second word holds feedback, prescaler, power-down
// - Swallow counter is 4 bits, 0..15
// - 24-bit word: 21 data over 3 address
// - MSB first; latch rise loads addressed word
// - Sync power-down waits for pump pulse end
module rfsd_top (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic ser_clk_i,
  input  wire logic ser_data_i,
  input  wire logic latch_enable_line_i,
  input  wire logic chip_enable_i,
  input  wire logic ref_in_i,
  input  wire logic vco_in_i,
  output var  logic pump_up_o,
  output var  logic pump_down_o,
  output var  logic pump_drive_o,
  output var  logic pump_gain_o,
  output var  logic power_down_o,
  output var  logic ref_div_o,
  output var  logic fb_div_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [23:0]             shift_word;
  logic [3:0]              pin_meta;
  logic [3:0]              pin_sync;
  logic [3:0]              pin_last;
  logic                    le_rise;
  logic                    chip_on;
  logic                    ref_tick;
  logic                    vco_tick;
  rfsd_pkg::rfsd_ref_s     ref_word;
  rfsd_pkg::rfsd_fb_s      fb_word;
  rfsd_pkg::rfsd_power_e   pwr_state;
  rfsd_pkg::rfsd_power_e   next_pwr;
  logic                    run;
  logic [14:0]             ref_cnt;
  logic [14:0]             ref_load;
  logic [14:0]             b_cnt;
  logic [14:0]             b_load;
  logic [3:0]              a_cnt;
  logic [3:0]              next_a;
  logic [4:0]              pre_cnt;
  logic [4:0]              mod_lo;
  logic [4:0]              start_pre;
  logic [4:0]              next_pre;
  logic                    up_flag;
  logic                    dn_flag;
  logic                    pump_active;
  logic                    next_drive;
  logic                    sync_req;
  logic                    async_req;

  // ****************************************
  // Serial shift register, link clock
  // ****************************************
  // No reset: only read after a latch rise, once fully shifted
  always_ff @(posedge ser_clk_i) begin
    shift_word <= {shift_word[22:0], ser_data_i};
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_last <= 4'h0;
    end else begin
      pin_meta <= {latch_enable_line_i, chip_enable_i,
                   ref_in_i, vco_in_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign le_rise  = pin_sync[3] & ~pin_last[3];
  assign chip_on  = pin_sync[2];
  assign ref_tick = pin_sync[1] & ~pin_last[1];
  assign vco_tick = pin_sync[0] & ~pin_last[0];

  // ****************************************
  // Control words
  // ****************************************
  // Shift word is quasi-static here: the serial clock is idle
  // for the two cycles the latch rise needs to cross over
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ref_word <= rfsd_pkg::rfsd_ref_s'(`RFSD_REF_RESET);
    end else if (le_rise &&
        shift_word[`RFSD_ADDR_MSB:0] == `RFSD_ADDR_REF) begin
      ref_word <= rfsd_pkg::rfsd_ref_s'(
        shift_word[`RFSD_WORD_MSB:`RFSD_DATA_LSB]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fb_word <= rfsd_pkg::rfsd_fb_s'(`RFSD_FB_RESET);
    end else if (le_rise &&
        shift_word[`RFSD_ADDR_MSB:0] == `RFSD_ADDR_FB) begin
      fb_word <= rfsd_pkg::rfsd_fb_s'(
        shift_word[`RFSD_WORD_MSB:`RFSD_DATA_LSB]);
    end
  end

  // ****************************************
  // Power modes
  // ****************************************
  assign async_req = ~chip_on |
    (fb_word.rf_power_down & ref_word.rf_pump_tristate);
  assign sync_req  = fb_word.rf_power_down &
    ~ref_word.rf_pump_tristate;

  // Sync mode waits for a pulse; a stalled reference never ends it
  always_comb begin
    next_pwr = pwr_state;
    case (pwr_state)
      rfsd_pkg::PWR_ACTIVE: begin
        if (async_req) begin
          next_pwr = rfsd_pkg::PWR_DOWN;
        end else if (sync_req) begin
          next_pwr = rfsd_pkg::PWR_WAIT_START;
        end
      end
      rfsd_pkg::PWR_WAIT_START: begin
        if (async_req) begin
          next_pwr = rfsd_pkg::PWR_DOWN;
        end else if (!sync_req) begin
          next_pwr = rfsd_pkg::PWR_ACTIVE;
        end else if (pump_active) begin
          next_pwr = rfsd_pkg::PWR_WAIT_END;
        end
      end
      rfsd_pkg::PWR_WAIT_END: begin
        if (async_req) begin
          next_pwr = rfsd_pkg::PWR_DOWN;
        end else if (!sync_req) begin
          next_pwr = rfsd_pkg::PWR_ACTIVE;
        end else if (!pump_active) begin
          next_pwr = rfsd_pkg::PWR_DOWN;
        end
      end
      rfsd_pkg::PWR_DOWN: begin
        if (chip_on && !fb_word.rf_power_down) begin
          next_pwr = rfsd_pkg::PWR_ACTIVE;
        end
      end
      default: begin
        next_pwr = rfsd_pkg::PWR_DOWN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pwr_state    <= rfsd_pkg::PWR_DOWN;
      power_down_o <= 1'b1;
    end else begin
      pwr_state    <= next_pwr;
      power_down_o <= (next_pwr == rfsd_pkg::PWR_DOWN);
    end
  end

  // ****************************************
  // Reference counter
  // ****************************************
  // Counters sit at their load point in reset and power-down
  assign run = ~ref_word.rf_counter_reset &
               (pwr_state != rfsd_pkg::PWR_DOWN);
  // Values below 3 are left to the host to avoid
  assign ref_load = ref_word.rf_reference_divide - 15'h0001;

  always_ff @(posedge mclk_i) begin
    if (reset_i || !run) begin
      ref_cnt   <= ref_load;
      ref_div_o <= 1'b0;
    end else begin
      ref_div_o <= 1'b0;
      if (ref_tick) begin
        if (ref_cnt == 15'h0000) begin
          ref_cnt   <= ref_load;
          ref_div_o <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt - 15'h0001;
        end
      end
    end
  end

  // ****************************************
  // Feedback divider: prescaler, swallow, binary
  // ****************************************
  assign mod_lo = fb_word.rf_prescaler_select ?
                  `RFSD_PRE_HI : `RFSD_PRE_LO;
  assign b_load = fb_word.rf_binary_count - 15'h0001;
  // Swallow cycles run at modulus plus one, then base modulus
  assign start_pre = (fb_word.rf_swallow_count != 4'h0) ?
                     mod_lo : mod_lo - 5'h01;
  assign next_a = (a_cnt != 4'h0) ? a_cnt - 4'h1 : 4'h0;
  assign next_pre = (next_a != 4'h0) ?
                    mod_lo : mod_lo - 5'h01;

  always_ff @(posedge mclk_i) begin
    if (reset_i || !run) begin
      pre_cnt  <= start_pre;
      a_cnt    <= fb_word.rf_swallow_count;
      b_cnt    <= b_load;
      fb_div_o <= 1'b0;
    end else begin
      fb_div_o <= 1'b0;
      if (vco_tick) begin
        if (pre_cnt != 5'h00) begin
          pre_cnt <= pre_cnt - 5'h01;
        end else if (b_cnt == 15'h0000) begin
          pre_cnt  <= start_pre;
          a_cnt    <= fb_word.rf_swallow_count;
          b_cnt    <= b_load;
          fb_div_o <= 1'b1;
        end else begin
          pre_cnt <= next_pre;
          a_cnt   <= next_a;
          b_cnt   <= b_cnt - 15'h0001;
        end
      end
    end
  end

  // ****************************************
  // Phase detector and charge pump
  // ****************************************
  assign pump_active = up_flag | dn_flag;

  always_ff @(posedge mclk_i) begin
    if (reset_i || !run) begin
      up_flag <= 1'b0;
      dn_flag <= 1'b0;
    end else if ((up_flag | ref_div_o) && (dn_flag | fb_div_o)) begin
      up_flag <= 1'b0;
      dn_flag <= 1'b0;
    end else begin
      up_flag <= up_flag | ref_div_o;
      dn_flag <= dn_flag | fb_div_o;
    end
  end

  // Tri-state acts on the next edge, not on a detector event
  assign next_drive = ~ref_word.rf_pump_tristate &
    (next_pwr != rfsd_pkg::PWR_DOWN);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pump_drive_o <= 1'b0;
      pump_gain_o  <= 1'b0;
      pump_up_o    <= 1'b0;
      pump_down_o  <= 1'b0;
    end else begin
      pump_drive_o <= next_drive;
      pump_gain_o  <= ref_word.rf_pump_gain;
      if (ref_word.rf_detector_polarity) begin
        pump_up_o   <= next_drive & up_flag;
        pump_down_o <= next_drive & dn_flag;
      end else begin
        pump_up_o   <= next_drive & dn_flag;
        pump_down_o <= next_drive & up_flag;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  a_ref_word_load: assert property (
    (le_rise && shift_word[2:0] == `RFSD_ADDR_REF) |=>
      ref_word == $past(shift_word[23:3]))
    else $error("reference word not loaded on latch");

  a_fb_word_load: assert property (
    (le_rise && shift_word[2:0] == `RFSD_ADDR_FB) |=>
      fb_word == $past(shift_word[23:3]))
    else $error("feedback word not loaded on latch");

  a_ref_reload: assert property (
    (run && ref_tick && ref_cnt == 15'h0000) |=>
      ref_div_o && ref_cnt == $past(ref_load))
    else $error("reference counter did not wrap");

  a_counters_held: assert property (
    !run |=> ref_cnt == $past(ref_load) && b_cnt == $past(b_load)
      && a_cnt == $past(fb_word.rf_swallow_count))
    else $error("counters not held at load point");

  a_restart_aligned: assert property (
    $rose(run) |-> ref_cnt == $past(ref_load)
      && b_cnt == $past(b_load))
    else $error("counters restarted out of alignment");

  a_pre_modulus: assert property (
    (run && vco_tick && pre_cnt == 5'h00 && b_cnt != 15'h0000) |=>
      pre_cnt == (($past(a_cnt) > 4'h1) ?
        $past(mod_lo) : $past(mod_lo) - 5'h01))
    else $error("prescaler modulus wrong for swallow state");

  a_tristate_off: assert property (
    ref_word.rf_pump_tristate |=> !pump_drive_o)
    else $error("pump driven while tri-stated");

  a_tristate_release: assert property (
    (!ref_word.rf_pump_tristate && next_pwr != rfsd_pkg::PWR_DOWN)
      |=> pump_drive_o)
    else $error("pump not driven after tri-state cleared");

  a_gain_level: assert property (
    ##1 pump_gain_o == $past(ref_word.rf_pump_gain))
    else $error("pump gain does not follow control bit");

  a_polarity_swap: assert property (
    (up_flag && !dn_flag && !ref_word.rf_detector_polarity
      && next_drive) |=> pump_down_o && !pump_up_o)
    else $error("negative polarity did not swap pump");

  a_async_down: assert property (
    async_req |=> power_down_o)
    else $error("asynchronous power-down not immediate");

  a_sync_waits: assert property (
    (pwr_state == rfsd_pkg::PWR_WAIT_END && pump_active
      && !async_req && sync_req) |=> !power_down_o)
    else $error("synchronous power-down cut a pump pulse");

  c_ref_latch: cover property (
    le_rise && shift_word[2:0] == `RFSD_ADDR_REF);

  c_fb_pulse: cover property (run && fb_div_o);

  c_sync_down: cover property (
    pwr_state == rfsd_pkg::PWR_WAIT_END ##1
    pwr_state == rfsd_pkg::PWR_DOWN);

endmodule : rfsd_top

`default_nettype wire

/* File: verification/rfsd_host_model.sv */
// Host model: drives the three-wire serial port of the divider block.
// Assumes the bench calls send() from one process at a time.
`default_nettype none
`timescale 1ns/1ns

// ****************************************
// Serial host
// ****************************************
module rfsd_host_model (
  output var logic ser_clk_o,
  output var logic ser_data_o,
  output var logic latch_o
);
  initial begin
    ser_clk_o  = 1'b0;
    ser_data_o = 1'b0;
    latch_o    = 1'b0;
  end

  // Link clock runs only inside a frame, 6 ns period
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      ser_data_o = word[i];
      #3 ser_clk_o = 1'b1;
      #3 ser_clk_o = 1'b0;
    end
    #3 latch_o = 1'b1;
    #40 latch_o = 1'b0;
    // Released line shows the inverse, never a stale bit
    ser_data_o = ~ser_data_o;
    #40;
  endtask : send
endmodule : rfsd_host_model

`default_nettype wire

/* File: verification/test_rfsd_top.sv */
// Testbench of the divider block: serial writes through the host model,
// reference and VCO edges from the bench, checks at the ports.
// Assumes rfsd_map.svh, the package and the host model compile first.
`default_nettype none
`timescale 1ns/1ns
`include "rfsd_map.svh"

module test_rfsd_top;
  logic mclk_i, reset_i, chip_enable_i, ref_in_i, vco_in_i;
  logic ser_clk, ser_data, latch;
  logic pump_up_o, pump_down_o, pump_drive_o, pump_gain_o;
  logic power_down_o, ref_div_o, fb_div_o;
  int   fails, checked, nref, nfb;
  int   fb_n;

  rfsd_host_model host (.ser_clk_o(ser_clk), .ser_data_o(ser_data),
                        .latch_o(latch));

  rfsd_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .ser_clk_i(ser_clk),
    .ser_data_i(ser_data), .latch_enable_line_i(latch),
    .chip_enable_i(chip_enable_i), .ref_in_i(ref_in_i),
    .vco_in_i(vco_in_i), .pump_up_o(pump_up_o),
    .pump_down_o(pump_down_o), .pump_drive_o(pump_drive_o),
    .pump_gain_o(pump_gain_o), .power_down_o(power_down_o),
    .ref_div_o(ref_div_o), .fb_div_o(fb_div_o));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (ref_div_o === 1'b1) nref++;
    if (fb_div_o === 1'b1) nfb++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Divide values never below 3 from this host
  function automatic logic [23:0] w0(input logic [3:0] f,
                                     input logic [14:0] r);
    return {2'b00, f, r, `RFSD_ADDR_REF};
  endfunction : w0

  function automatic logic [23:0] w1(input logic pd,
                                     input logic [3:0] a);
    return {pd, 1'b0, 15'h0003, a, `RFSD_ADDR_FB};
  endfunction : w1

  task automatic put(input logic [23:0] w);
    host.send(w);
    tick(2);
  endtask : put

  // Pins high 2 and low 2 cycles, well inside the input rate limit
  task automatic edges(input logic vco, input int n);
    nref = 0;
    nfb  = 0;
    for (int i = 0; i < n; i++) begin
      if (vco) vco_in_i = 1'b1;
      else ref_in_i = 1'b1;
      tick(2);
      vco_in_i = 1'b0;
      ref_in_i = 1'b0;
      tick(2);
    end
    tick(8);
  endtask : edges

  task automatic give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    fails++;
    give_verdict;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    reset_i       = 1'b1;
    chip_enable_i = 1'b1;
    ref_in_i      = 1'b0;
    vco_in_i      = 1'b0;
    fb_n          = `RFSD_PRE_LO * 3 + 2;
    tick(12);
    reset_i = 1'b0;
    tick(1);
    chk(power_down_o, 1'b1);
    chk({pump_drive_o, pump_gain_o, pump_up_o}, 3'h0);
    // Power up, gain high, polarity positive, R at its minimum
    put(w1(1'b0, 4'h2));
    put(w0(4'b0011, 15'h0003));
    chk(power_down_o, 1'b0);
    chk(pump_gain_o, 1'b1);
    chk(pump_drive_o, 1'b1);
    // Unused address with all ones must change nothing
    put({21'h1FFFFF, 3'h2});
    chk({pump_drive_o, pump_gain_o, power_down_o}, 3'h6);
    edges(1'b0, 9);
    chk(nref[15:0], 16'h0003);
    chk({pump_up_o, pump_down_o}, 2'b10);
    edges(1'b1, 2 * fb_n);
    chk(nfb[15:0], 16'h0002);
    chk({pump_up_o, pump_down_o}, 2'b01);
    // Tri-state forces the pump off without any counter event
    put(w0(4'b0111, 15'h0003));
    chk({pump_drive_o, pump_up_o, pump_down_o}, 3'h0);
    put(w0(4'b0011, 15'h0003));
    chk(pump_drive_o, 1'b1);
    put(w0(4'b1011, 15'h0003));
    edges(1'b0, 9);
    chk(nref[15:0], 16'h0000);
    chk(pump_down_o, 1'b0);
    put(w0(4'b0011, 15'h0003));
    // Negative polarity swaps the pump outputs
    put(w0(4'b0010, 15'h0003));
    edges(1'b0, 3);
    chk({pump_up_o, pump_down_o}, 2'b01);
    edges(1'b1, fb_n);
    chk({pump_up_o, pump_down_o}, 2'b00);
    // Sync power-down waits for a whole pump pulse
    put(w1(1'b1, 4'h2));
    tick(8);
    chk(power_down_o, 1'b0);
    edges(1'b0, 3);
    chk(power_down_o, 1'b0);
    edges(1'b1, fb_n);
    chk(power_down_o, 1'b1);
    put(w1(1'b0, 4'h2));
    chk(power_down_o, 1'b0);
    chip_enable_i = 1'b0;
    tick(6);
    chk(power_down_o, 1'b1);
    chip_enable_i = 1'b1;
    tick(6);
    chk(power_down_o, 1'b0);
    // Tri-state with power-down goes down at once
    put(w0(4'b0111, 15'h0003));
    put(w1(1'b1, 4'h2));
    chk(power_down_o, 1'b1);
    // Wide prescaler; pump stays tri-stated while the loop runs
    put({1'b0, 1'b1, 15'h0003, 4'h2, `RFSD_ADDR_FB});
    chk({power_down_o, pump_drive_o}, 2'b00);
    edges(1'b1, `RFSD_PRE_HI * 3 + 2);
    chk(nfb[15:0], 16'h0001);
    give_verdict;
  end
endmodule : test_rfsd_top

`default_nettype wire
